// ### hdl/bfcp_consts.vh
// bfcp_consts.vh: register map, command codes and timing counts for the flash controller
`ifndef BFCP_CONSTS_VH
`define BFCP_CONSTS_VH
// ----------------------------------------
// controller register word offsets (byte address = 4 * index)
// ----------------------------------------
`define BFCP_REG_CTRL 4'h0
`define BFCP_REG_ADDR 4'h1
`define BFCP_REG_WDATA 4'h2
`define BFCP_REG_STATUS 4'h3
`define BFCP_REG_RDATA 4'h4
`define BFCP_REG_ID 4'h5
// ----------------------------------------
// control register fields
// ----------------------------------------
`define BFCP_CTRL_OP_LSB 0
`define BFCP_CTRL_OP_MSB 3
`define BFCP_CTRL_VPP_BIT 8
// ----------------------------------------
// operation codes written to control
// ----------------------------------------
`define BFCP_OP_READ 4'h1
`define BFCP_OP_READ_CMD 4'h2
`define BFCP_OP_IDENT 4'h3
`define BFCP_OP_ERASE 4'h4
`define BFCP_OP_ERASE_VERIFY 4'h5
`define BFCP_OP_PROGRAM 4'h6
`define BFCP_OP_PROGRAM_VERIFY 4'h7
`define BFCP_OP_RESET 4'h8
`define BFCP_OP_HW_IDENT 4'h9
// ----------------------------------------
// device command latch codes
// ----------------------------------------
`define BFCP_CMD_READ 8'h00
`define BFCP_CMD_IDENT 8'h90
`define BFCP_CMD_ERASE 8'h20
`define BFCP_CMD_ERASE_VERIFY 8'ha0
`define BFCP_CMD_PROGRAM 8'h40
`define BFCP_CMD_PROGRAM_VERIFY 8'hc0
`define BFCP_CMD_RESET 8'hff
`define BFCP_ERASED_BYTE 8'hff
// ----------------------------------------
// timing at 50 MHz
// ----------------------------------------
`define BFCP_CLK_MHZ 50
`define BFCP_PHASE_CYC 4
`define BFCP_RECOVERY_US 6
`define BFCP_RECOVERY_CYC (`BFCP_RECOVERY_US * `BFCP_CLK_MHZ)
`endif

// ### hdl/bfcp_ctrl.v
// bfcp_ctrl.v: host controller driving a bulk-erase flash over its parallel bus pins
`timescale 1ns/1ns
`include "bfcp_consts.vh"
// ----------------------------------------
// controller
// ----------------------------------------
// Overview of operation
// [RQ1] supply low: device only reads; controller issues no writes then
// [RQ2] data driven by device only with chip select and output gate low
// [RQ3] chip select high: standby, device floats data
// [RQ4] deselect does not abort erase or program; controller ends it by command
// [RQ5] output gate high floats the device data pins
// [RQ6] identifier: address nine override, others low except bit zero, supply low
// [RQ7] identifier bytes odd parity on data bit seven; controller flags it
// [RQ8] command latch writes work only with supply high
// [RQ9] latch has no array address; it stores command with address and data
// [RQ10] write: select and strobe low, gate high; address fall, data rise
// [RQ11] gate low during a write blocks execution; controller keeps gate high
// [RQ12] commands carry code in bits seven to five, zeros below; controller writes 90 for identifier and ff for reset
// [RQ13] latch reads as read command when supply low or at power-up
// [RQ14] after read command wait before first array read
// [RQ15] identifier command then reads at address zero and one
// [RQ16] first erase write only arms
// [RQ17] second erase write starts bulk erase at strobe rise, no address
// [RQ18] erase runs until erase-verify with byte address; next read is verify data
// [RQ19] erase-verify address taken at its command write
// [RQ20] program set-up then write of target address and byte
// [RQ21] program-verify then read returns programmed byte without new address
// [RQ22] two reset writes return latch to reset condition
// [RQ23] erase-verify strobe rise ends the erase pulse
// [RQ24] erased byte reads all ones in erase-verify
// [RQ25] program-verify write ends the programming pulse
// [RQ26] undefined code leaves array intact and selects read mode
module bfcp_ctrl #(
  parameter RECOVERY_CYC = `BFCP_RECOVERY_CYC
) (
  input wire clk_sys,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [17:0] flash_addr,
  output reg flash_id_override,
  output reg [7:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [7:0] flash_dq_in,
  output reg flash_chip_sel_n,
  output reg flash_out_gate_n,
  output reg flash_write_n,
  output reg flash_vpp_high
);
// ----------------------------------------
// state
// ----------------------------------------
localparam ST_IDLE = 4'h0;
localparam ST_W_SETUP = 4'h1;
localparam ST_W_PULSE = 4'h2;
localparam ST_W_HOLD = 4'h3;
localparam ST_GAP = 4'h4;
localparam ST_WAIT = 4'h5;
localparam ST_R_SETUP = 4'h6;
localparam ST_R_SAMPLE = 4'h7;
localparam ST_DONE = 4'h8;

reg [3:0] state;
reg [3:0] op;
reg [1:0] step;
reg [15:0] cnt;
reg [17:0] addr_reg;
reg [7:0] wdata_reg;
reg [7:0] rdata;
reg [7:0] id_maker;
reg [7:0] id_device;
reg busy;
reg erase_active;
reg program_active;
reg refused;
reg parity_bad;
reg erased_ok;
reg [7:0] cur_byte;
reg [17:0] cur_addr;
reg cur_use_addr;

// ----------------------------------------
// helpers
// ----------------------------------------
function odd_parity;
  input [7:0] b;
  begin
    odd_parity = ^b;
  end
endfunction

// which write cycles an operation issues and whether it ends in a read
function [7:0] op_cmd;
  input [3:0] o;
  input [1:0] s;
  begin
    case (o)
      `BFCP_OP_READ_CMD: op_cmd = `BFCP_CMD_READ;
      `BFCP_OP_IDENT: op_cmd = `BFCP_CMD_IDENT;
      `BFCP_OP_ERASE: op_cmd = `BFCP_CMD_ERASE;
      `BFCP_OP_ERASE_VERIFY: op_cmd = `BFCP_CMD_ERASE_VERIFY;
      `BFCP_OP_PROGRAM: op_cmd = `BFCP_CMD_PROGRAM;
      `BFCP_OP_PROGRAM_VERIFY: op_cmd = `BFCP_CMD_PROGRAM_VERIFY;
      `BFCP_OP_RESET: op_cmd = `BFCP_CMD_RESET;
      default: op_cmd = `BFCP_CMD_READ; // [RQ26]
    endcase
  end
endfunction

wire needs_vpp = (op != `BFCP_OP_READ) && (op != `BFCP_OP_HW_IDENT);
wire [1:0] n_writes = (op == `BFCP_OP_ERASE || op == `BFCP_OP_PROGRAM || op == `BFCP_OP_RESET ||
                       op == `BFCP_OP_IDENT) ? 2'h2 : 2'h1;
wire ends_in_read = (op == `BFCP_OP_ERASE_VERIFY) || (op == `BFCP_OP_PROGRAM_VERIFY) ||
                    (op == `BFCP_OP_IDENT) || (op == `BFCP_OP_READ) || (op == `BFCP_OP_HW_IDENT);
// every op that leaves the latch in read mode except reset needs the wait, undefined codes too [RQ14] [RQ26]
wire waits_recovery = (op == `BFCP_OP_ERASE_VERIFY) || (op == `BFCP_OP_PROGRAM_VERIFY) ||
                      (op_cmd(op, 2'h0) == `BFCP_CMD_READ) || (op == `BFCP_OP_IDENT);

// ----------------------------------------
// avalon slave: reads and writes answer in the same cycle
// ----------------------------------------
assign avs_waitrequest = 1'b0;
wire ctrl_wr = avs_write && (avs_address == `BFCP_REG_CTRL);

always @* begin
  case (avs_address)
    `BFCP_REG_ADDR: avs_readdata = {14'h0000, addr_reg};
    `BFCP_REG_WDATA: avs_readdata = {24'h000000, wdata_reg};
    `BFCP_REG_STATUS: avs_readdata = {24'h000000, 1'b0, erased_ok, parity_bad, refused, program_active,
                                      erase_active, flash_vpp_high, busy};
    `BFCP_REG_RDATA: avs_readdata = {24'h000000, rdata};
    `BFCP_REG_ID: avs_readdata = {16'h0000, id_device, id_maker};
    default: avs_readdata = 32'h00000000;
  endcase
end

// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge clk_sys or posedge rst) begin
  if (rst) begin
    state <= ST_IDLE;
    op <= 4'h0;
    step <= 2'h0;
    cnt <= 16'h0000;
    addr_reg <= 18'h00000;
    wdata_reg <= 8'h00;
    rdata <= 8'h00;
    id_maker <= 8'h00;
    id_device <= 8'h00;
    busy <= 1'b0;
    erase_active <= 1'b0;
    program_active <= 1'b0;
    refused <= 1'b0;
    parity_bad <= 1'b0;
    erased_ok <= 1'b0;
    cur_byte <= 8'h00;
    cur_addr <= 18'h00000;
    cur_use_addr <= 1'b0;
    flash_addr <= 18'h00000;
    flash_id_override <= 1'b0;
    flash_dq_out <= 8'h00;
    flash_dq_oe <= 1'b0;
    flash_chip_sel_n <= 1'b1; // [RQ3]
    flash_out_gate_n <= 1'b1;
    flash_write_n <= 1'b1;
    flash_vpp_high <= 1'b0; // [RQ13]
  end else begin
    if (avs_write && !busy) begin
      if (avs_address == `BFCP_REG_ADDR) addr_reg <= avs_writedata[17:0];
      if (avs_address == `BFCP_REG_WDATA) wdata_reg <= avs_writedata[7:0];
      if (ctrl_wr) flash_vpp_high <= avs_writedata[`BFCP_CTRL_VPP_BIT];
    end
    case (state)
      ST_IDLE: begin
        if (ctrl_wr && !busy && avs_writedata[`BFCP_CTRL_OP_MSB:`BFCP_CTRL_OP_LSB] != 4'h0) begin
          op <= avs_writedata[`BFCP_CTRL_OP_MSB:`BFCP_CTRL_OP_LSB];
          step <= 2'h0;
          busy <= 1'b1;
          refused <= 1'b0;
          state <= ST_GAP;
          cnt <= 16'h0000;
        end
      end
      ST_GAP: begin
        // the op latched last cycle is decoded here; supply read from control bit
        if (needs_vpp && !flash_vpp_high) begin
          refused <= 1'b1; // [RQ1] [RQ8]
          busy <= 1'b0;
          state <= ST_IDLE;
        end else if (!needs_vpp) begin
          flash_vpp_high <= 1'b0; // [RQ6]
          state <= ST_R_SETUP;
          cnt <= 16'h0000;
        end else begin
          cur_byte <= (op == `BFCP_OP_PROGRAM && step == 2'h1) ? wdata_reg : op_cmd(op, step); // [RQ12] [RQ20]
          cur_use_addr <= (op == `BFCP_OP_ERASE_VERIFY) || (op == `BFCP_OP_PROGRAM && step == 2'h1); // [RQ9]
          cur_addr <= addr_reg;
          state <= ST_W_SETUP;
        end
      end
      ST_W_SETUP: begin
        // select, gate high, then strobe falls with address stable [RQ10] [RQ11]
        flash_out_gate_n <= 1'b1;
        flash_chip_sel_n <= 1'b0;
        flash_addr <= cur_use_addr ? cur_addr : 18'h00000; // [RQ17] [RQ19]
        flash_dq_out <= cur_byte;
        flash_dq_oe <= 1'b1;
        if (cnt == `BFCP_PHASE_CYC) begin
          flash_write_n <= 1'b0;
          cnt <= 16'h0000;
          state <= ST_W_PULSE;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
      ST_W_PULSE: begin
        if (cnt == `BFCP_PHASE_CYC) begin
          flash_write_n <= 1'b1; // data taken on this rise [RQ10]
          cnt <= 16'h0000;
          state <= ST_W_HOLD;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
      ST_W_HOLD: begin
        flash_dq_oe <= 1'b0;
        flash_chip_sel_n <= 1'b1; // deselect is safe mid-operation [RQ4]
        if (op == `BFCP_OP_ERASE && step == 2'h1) erase_active <= 1'b1; // [RQ16] [RQ17]
        if (op == `BFCP_OP_PROGRAM && step == 2'h1) program_active <= 1'b1;
        if (op == `BFCP_OP_ERASE_VERIFY) erase_active <= 1'b0; // [RQ23] [RQ18]
        if (op == `BFCP_OP_PROGRAM_VERIFY) program_active <= 1'b0; // [RQ25]
        if (op == `BFCP_OP_RESET && step == 2'h1) begin
          erase_active <= 1'b0; // [RQ22]
          program_active <= 1'b0;
        end
        if (step + 2'h1 < n_writes) begin
          step <= step + 2'h1;
          state <= ST_GAP;
        end else if (waits_recovery) begin
          cnt <= 16'h0000;
          state <= ST_WAIT;
        end else begin
          state <= ST_DONE;
        end
      end
      ST_WAIT: begin
        if (cnt == RECOVERY_CYC[15:0]) begin // [RQ14]
          cnt <= 16'h0000;
          step <= 2'h0;
          state <= ends_in_read ? ST_R_SETUP : ST_DONE;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
      ST_R_SETUP: begin
        // read: select and gate low, device drives data [RQ2]
        flash_dq_oe <= 1'b0;
        flash_write_n <= 1'b1;
        flash_chip_sel_n <= 1'b0;
        flash_out_gate_n <= 1'b0;
        flash_id_override <= (op == `BFCP_OP_HW_IDENT); // [RQ6]
        if (op == `BFCP_OP_HW_IDENT || op == `BFCP_OP_IDENT)
          flash_addr <= {17'h00000, step[0]}; // [RQ6] [RQ15]
        else
          flash_addr <= addr_reg; // [RQ21] address unused by device in verify reads
        if (cnt == `BFCP_PHASE_CYC) begin
          cnt <= 16'h0000;
          state <= ST_R_SAMPLE;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
      ST_R_SAMPLE: begin
        flash_out_gate_n <= 1'b1; // [RQ5]
        flash_chip_sel_n <= 1'b1;
        rdata <= flash_dq_in;
        if (op == `BFCP_OP_ERASE_VERIFY) erased_ok <= (flash_dq_in == `BFCP_ERASED_BYTE); // [RQ24]
        if ((op == `BFCP_OP_HW_IDENT || op == `BFCP_OP_IDENT) && step == 2'h0) begin
          id_maker <= flash_dq_in;
          parity_bad <= !odd_parity(flash_dq_in); // [RQ7]
          step <= 2'h1;
          state <= ST_R_SETUP;
        end else begin
          if (op == `BFCP_OP_HW_IDENT || op == `BFCP_OP_IDENT) begin
            id_device <= flash_dq_in;
            parity_bad <= parity_bad | !odd_parity(flash_dq_in); // [RQ7]
          end
          state <= ST_DONE;
        end
      end
      ST_DONE: begin
        flash_id_override <= 1'b0;
        flash_addr <= 18'h00000;
        busy <= 1'b0;
        state <= ST_IDLE;
      end
      default: state <= ST_IDLE;
    endcase
  end
end

endmodule

// ### dv/bfcp_ctrl_chk.sv
// bfcp_ctrl_chk.sv: pin-level checker for the flash controller
`timescale 1ns/1ns
module bfcp_ctrl_chk #(
  parameter RECOVERY_CYC = 300
) (
  input wire clk_sys,
  input wire rst,
  input wire [17:0] flash_addr,
  input wire flash_id_override,
  input wire [7:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire flash_chip_sel_n,
  input wire flash_out_gate_n,
  input wire flash_write_n,
  input wire flash_vpp_high
);
  reg [7:0] lastb;
  reg [9:0] since;
  wire slow;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper: cycles since the last strobe
  // ----------------------------------------
  // saturates so a long idle never wraps into a false short gap
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lastb <= 8'h55;
      since <= 10'h000;
    end else if (!flash_write_n) begin
      lastb <= flash_dq_out;
      since <= 10'h000;
    end else if (since != 10'h3ff) begin
      since <= since + 10'h001;
    end
  end
  assign slow = flash_vpp_high && (lastb == 8'h00 || lastb == 8'h90 || lastb == 8'ha0 || lastb == 8'hc0);
  sequence s_pulse;
    !flash_write_n [*4] ##[1:3] flash_write_n;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_VPP_FOR_WRITE: assert property (!flash_write_n |-> flash_vpp_high)
    else $error("strobe low without programming supply");
  AST_WRITE_PINS: assert property (!flash_write_n
    |-> !flash_chip_sel_n && flash_out_gate_n && flash_dq_oe)
    else $error("bad pin state during write strobe");
  AST_NO_CONTENTION: assert property (flash_dq_oe |-> flash_out_gate_n)
    else $error("controller drives data while gate low");
  AST_PULSE_SHAPE: assert property ($fell(flash_write_n) |-> s_pulse)
    else $error("write pulse length wrong");
  AST_LATCH_STABLE: assert property ($rose(flash_write_n) |-> $stable(flash_dq_out) && $stable(flash_addr))
    else $error("address or data moved at strobe rise");
  AST_HOLD_DESELECT: assert property ($rose(flash_write_n) |-> ##[0:2] flash_chip_sel_n && !flash_dq_oe)
    else $error("no deselect after write");
  AST_ID_PINS: assert property (flash_id_override |-> !flash_vpp_high && flash_write_n
    && flash_addr[17:10] == 8'h00 && flash_addr[8:1] == 8'h00)
    else $error("identifier override with wrong pins");
  AST_RECOVERY: assert property ($fell(flash_out_gate_n) && slow |-> since >= RECOVERY_CYC)
    else $error("read too soon after command");
  AST_RESET_IDLE: assert property ($fell(rst)
    |-> flash_chip_sel_n && flash_write_n && !flash_vpp_high && !flash_dq_oe)
    else $error("pins not idle after reset");
  // only erase-verify and program data writes may carry an address
  AST_CMD_NO_ADDR: assert property ($fell(flash_write_n) && flash_dq_out != 8'ha0 && lastb != 8'h40
    |-> flash_addr == 18'h00000)
    else $error("command write carries an address");
endmodule

// ### dv/bfcp_flash_model.sv
// bfcp_flash_model.sv: behavioural bulk-erase flash device on the parallel bus
`timescale 1ns/1ns
module bfcp_flash_model #(
  parameter MAKER = 8'h15,
  parameter DEVICE = 8'h83
) (
  input wire [17:0] addr,
  input wire id_override,
  input wire [7:0] ctl_dq,
  input wire ctl_oe,
  output wire [7:0] dq,
  input wire chip_sel_n,
  input wire out_gate_n,
  input wire write_n,
  input wire vpp_high
);
  reg [7:0] mem [0:255];
  reg [7:0] cmd = 8'h00;
  reg [7:0] last = 8'h00;
  reg [7:0] rd;
  reg [17:0] wa = 0;
  reg [17:0] pa = 0;
  reg [17:0] ea = 0;
  reg arm_e = 0;
  reg arm_p = 0;
  reg rst1 = 0;
  integer i;
  wire wr_ok = !chip_sel_n && out_gate_n && vpp_high;
  wire drive = !chip_sel_n && !out_gate_n;
  // ----------------------------------------
  // read path and bus level
  // ----------------------------------------
  // codes are arbitrary, chosen with odd parity on data bit seven
  always @* begin
    if (id_override && !vpp_high) rd = addr[0] ? DEVICE : MAKER;
    else case (cmd)
      8'h80, 8'h90: rd = addr[0] ? DEVICE : MAKER;
      8'ha0: rd = mem[ea[7:0]];
      8'hc0: rd = mem[pa[7:0]];
      default: rd = mem[addr[7:0]];
    endcase
  end
  // released bus shows the inverse of the last level
  assign dq = ctl_oe ? ctl_dq : drive ? rd : ~last;
  always @(ctl_oe or drive or ctl_dq or rd) if (ctl_oe) last = ctl_dq; else if (drive) last = rd;
  // ----------------------------------------
  // command latch
  // ----------------------------------------
  initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
  always @(negedge vpp_high) cmd = 8'h00;
  always @(negedge write_n) if (wr_ok) wa = addr;
  // deselect leaves erasing untouched; only a0 ends it
  always @(posedge write_n) if (wr_ok) begin
    if (arm_p) begin
      mem[wa[7:0]] = mem[wa[7:0]] & ctl_dq;
      pa = wa;
      arm_p = 0;
    end else begin
      case (ctl_dq)
        8'h20: if (arm_e) begin
          for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
        end
        8'h40: arm_p = 1;
        8'ha0: begin
          ea = wa;
          cmd = 8'ha0;
        end
        8'hc0: cmd = 8'hc0;
        8'h00, 8'h80, 8'h90: cmd = ctl_dq;
        8'hff: if (rst1) cmd = 8'h00;
        default: cmd = 8'h00;
      endcase
      arm_e = (ctl_dq == 8'h20) && !arm_e;
      rst1 = (ctl_dq == 8'hff) && !rst1;
    end
  end
endmodule

// ### dv/bfcp_ctrl_test.sv
// bfcp_ctrl_test.sv: self-checking bench for the flash controller
`timescale 1ns/1ns
`include "bfcp_consts.vh"
module bfcp_ctrl_test;
  localparam RECOVERY_CYC = 10;
  localparam [7:0] MAKER = 8'h15;
  localparam [7:0] DEVICE = 8'h83;
  reg clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, mark = 0;
  reg [3:0] avs_address = 0;
  reg [31:0] avs_writedata = 0, q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, fid, foe, fcs, fog, fwe, fvpp;
  wire [17:0] fa;
  wire [7:0] fdo, fdi;
  integer bad_count = 0, checked = 0, cyc = 0;
  reg [63:0] exp_q[$];
  reg [63:0] me;
  reg [7:0] rnd = 8'h57, pa, pd;
  always #10 clk_sys = ~clk_sys;
  bfcp_ctrl #(.RECOVERY_CYC(RECOVERY_CYC)) dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_addr(fa), .flash_id_override(fid), .flash_dq_out(fdo),
    .flash_dq_oe(foe), .flash_dq_in(fdi), .flash_chip_sel_n(fcs), .flash_out_gate_n(fog),
    .flash_write_n(fwe), .flash_vpp_high(fvpp));
  bfcp_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) mdl (.addr(fa), .id_override(fid), .ctl_dq(fdo),
    .ctl_oe(foe), .dq(fdi), .chip_sel_n(fcs), .out_gate_n(fog), .write_n(fwe), .vpp_high(fvpp));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] expv, input [31:0] m);
    checked = checked + 1;
    if ((seen & m) !== (expv & m)) begin
      bad_count = bad_count + 1;
      $display("wrong value readdata expected %h seen %h", expv & m, seen & m);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task bus(input w, input [3:0] a, input [31:0] d, input ck);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    mark <= ck;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    mark <= 0;
  endtask
  task rd(input [3:0] a, input [31:0] e, input [31:0] m);
    exp_q.push_back({m, e});
    bus(0, a, 0, 1);
  endtask
  // a hang here is ended by the cycle ceiling below
  task op(input [31:0] c);
    bus(1, `BFCP_REG_CTRL, c, 0);
    do begin
      bus(0, `BFCP_REG_STATUS, 0, 0);
    end while (q[0] !== 1'b0);
  endtask
  always @(posedge clk_sys) if (avs_read && mark && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
    me = exp_q.pop_front();
    check(avs_readdata, me[31:0], me[63:32]);
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    rd(`BFCP_REG_STATUS, 0, 32'h1f);
    rd(4'hf, 0, 32'hffffffff);
    op(`BFCP_OP_ERASE);
    rd(`BFCP_REG_STATUS, 32'h10, 32'h16);
    rnd = lfsr(rnd);
    pa = rnd;
    rnd = lfsr(rnd);
    pd = rnd;
    bus(1, `BFCP_REG_ADDR, {24'h0, pa}, 0);
    bus(1, `BFCP_REG_WDATA, {24'h0, pd}, 0);
    op(32'h100 | `BFCP_OP_ERASE);
    rd(`BFCP_REG_STATUS, 32'h06, 32'h06);
    op(32'h100 | `BFCP_OP_ERASE_VERIFY);
    rd(`BFCP_REG_RDATA, 32'hff, 32'hff);
    rd(`BFCP_REG_STATUS, 32'h40, 32'h44);
    op(32'h100 | `BFCP_OP_PROGRAM);
    rd(`BFCP_REG_STATUS, 32'h08, 32'h08);
    op(32'h100 | `BFCP_OP_PROGRAM_VERIFY);
    rd(`BFCP_REG_RDATA, {24'h0, pd}, 32'hff);
    op(32'h100 | `BFCP_OP_READ_CMD);
    op(32'h100 | `BFCP_OP_READ);
    rd(`BFCP_REG_RDATA, {24'h0, pd}, 32'hff);
    op(32'h100 | `BFCP_OP_IDENT);
    rd(`BFCP_REG_ID, {16'h0, DEVICE, MAKER}, 32'hffff);
    rd(`BFCP_REG_STATUS, 32'h0, 32'h20);
    op(32'h100 | `BFCP_OP_HW_IDENT);
    rd(`BFCP_REG_ID, {16'h0, DEVICE, MAKER}, 32'hffff);
    rd(`BFCP_REG_STATUS, 32'h0, 32'h02);
    op(32'h100 | `BFCP_OP_RESET);
    op(32'h100 | `BFCP_OP_READ);
    rd(`BFCP_REG_RDATA, {24'h0, pd}, 32'hff);
    bus(1, `BFCP_REG_ADDR, {24'h0, pa ^ 8'h01}, 0);
    op(32'h100 | 4'ha);
    op(32'h100 | `BFCP_OP_READ);
    rd(`BFCP_REG_RDATA, 32'hff, 32'hff);
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    rd(`BFCP_REG_STATUS, 0, 32'h1f);
    final_report;
  end
endmodule
bind bfcp_ctrl bfcp_ctrl_chk #(.RECOVERY_CYC(RECOVERY_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .flash_addr(flash_addr), .flash_id_override(flash_id_override),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_chip_sel_n(flash_chip_sel_n),
  .flash_out_gate_n(flash_out_gate_n), .flash_write_n(flash_write_n), .flash_vpp_high(flash_vpp_high));
